// ==== logic/rft_consts.svh ====
// Register indices, field positions, limits and timing constants
`ifndef RFT_CONSTS_SVH
`define RFT_CONSTS_SVH

// Register word indices (byte address = index * 4)
`define RFT_I_CTRL 4'h0
`define RFT_I_OFFX 4'h1
`define RFT_I_OFFY 4'h2
`define RFT_I_WIDTH 4'h3
`define RFT_I_HEIGHT 4'h4
`define RFT_I_PIXFMT 4'h5
`define RFT_I_CFILT 4'h6
`define RFT_I_TPAT 4'h7
`define RFT_I_RATE 4'h8
`define RFT_I_TAP 4'h9
`define RFT_I_TSEL 4'hA
`define RFT_I_TMODE 4'hB
`define RFT_I_TSW 4'hC
`define RFT_I_TSRC 4'hD
`define RFT_I_TACT 4'hE
`define RFT_I_STAT 4'hF

// Field positions
`define RFT_CTRL_RUN 0
`define RFT_CTRL_BYP 1
`define RFT_TSW_FIRE 0

// Geometry limits
`define RFT_SENSOR_W 12'h790
`define RFT_SENSOR_H 12'h4C0
`define RFT_OFFX_MAX 11'h730
`define RFT_OFFY_MAX 11'h4BE
`define RFT_WIDTH_MIN 11'h060
`define RFT_HEIGHT_MIN 11'h002
`define RFT_WIDTH_RST 11'h790
`define RFT_HEIGHT_RST 11'h4C0

// Frame rate in millihertz
`define RFT_RATE_MIN 17'h0007D
`define RFT_RATE_MAX 17'h1F3E7
`define RFT_RATE_RST 17'h1D563
`define RFT_CLK_HZ 36'h001312D00
`define RFT_MHZ_PER_HZ 36'h0000003E8
`define RFT_ACC_WRAP (`RFT_CLK_HZ * `RFT_MHZ_PER_HZ)

// Trigger defaults and fixed codes
`define RFT_RST_SRC 4'h7
`define RFT_RST_ACT 2'h0
`define RFT_TSEL_FRAME_START 32'h00000000
`define RFT_SRC_LAST 4'h9

// Bus responses
`define RFT_RESP_OKAY 2'h0
`define RFT_RESP_SLVERR 2'h2
`define RFT_RESP_DECERR 2'h3

`endif

// ==== logic/rft_pkg.sv ====
// Types shared by the format and trigger block
package rft_pkg;

	typedef enum logic [1:0] {RFT_PF_8 = 2'h0, RFT_PF_10 = 2'h1, RFT_PF_12 = 2'h2} rft_pixfmt_t;

	typedef enum logic [2:0] {
		RFT_TP_OFF = 3'h0, RFT_TP_GREY_H = 3'h1, RFT_TP_GREY_V = 3'h2, RFT_TP_GREY_H_MOVE = 3'h3,
		RFT_TP_BAR_H = 3'h4, RFT_TP_BAR_V = 3'h5, RFT_TP_BAR_MOVE = 3'h6
	} rft_pat_t;

	typedef enum logic [3:0] {
		RFT_SRC_LOW = 4'h0, RFT_SRC_HIGH = 4'h1, RFT_SRC_SOFT = 4'h2, RFT_SRC_PULSE_ZERO = 4'h3,
		RFT_SRC_USER_ZERO = 4'h4, RFT_SRC_USER_ONE = 4'h5, RFT_SRC_TTL = 4'h6, RFT_SRC_CC1 = 4'h7,
		RFT_SRC_NAND_A = 4'h8, RFT_SRC_NAND_B = 4'h9
	} rft_src_t;

	typedef enum logic [1:0] {RFT_ACT_RISE = 2'h0, RFT_ACT_FALL = 2'h1, RFT_ACT_HIGH = 2'h2, RFT_ACT_LOW = 2'h3} rft_act_t;

	typedef enum logic [1:0] {RFT_SC_IDLE = 2'b00, RFT_SC_LINE = 2'b01, RFT_SC_HBLK = 2'b11} rft_scan_st_t;

	typedef struct packed {
		logic [10:0] offset_x;
		logic [10:0] offset_y;
		logic [10:0] width;
		logic [10:0] height;
	} rft_roi_t;

	typedef struct packed {
		logic valid;
		logic sof;
		logic eol;
		logic [11:0] data;
	} rft_pix_t;

endpackage

// ==== logic/rft_scan.sv ====
// Region readout scanner with test pattern and pixel format stage
`timescale 1ns/1ps
`include "rft_consts.svh"
module rft_scan #(
	parameter int HBLANK = 64
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic start, // Begin one frame
	input wire rft_pkg::rft_roi_t roi, // Region settings
	input wire logic tap, // Two-tap readout
	input wire rft_pkg::rft_pat_t pattern, // Test image select
	input wire rft_pkg::rft_pixfmt_t pixfmt, // Output depth
	input wire logic [7:0] frame_idx, // Frame counter
	input wire logic [11:0] sensor_pixel, // Data at current address
	output logic busy, // Readout in progress
	output logic [10:0] sensor_col, // Sensor column address
	output logic [10:0] sensor_row, // Sensor row address
	output rft_pkg::rft_pix_t pix // Output pixel
);
	import rft_pkg::*;

	if (HBLANK < 8 || HBLANK > 1023) begin : g_chk
		$error("rft_scan: HBLANK out of range");
	end

	localparam logic [9:0] HB = HBLANK[9:0];

	function automatic logic [11:0] pat_val(rft_pat_t p, logic [10:0] c, logic [10:0] r, logic [7:0] f);
		logic [10:0] mc;
		mc = c + {1'b0, f, 2'h0};
		case (p)
			RFT_TP_GREY_H: pat_val = {1'b0, c};
			RFT_TP_GREY_V: pat_val = {1'b0, r};
			RFT_TP_GREY_H_MOVE: pat_val = {1'b0, mc};
			RFT_TP_BAR_H: pat_val = {c[10:8], 9'h1FF};
			RFT_TP_BAR_V: pat_val = {r[10:8], 9'h1FF};
			RFT_TP_BAR_MOVE: pat_val = {mc[10:8], 9'h1FF};
			default: pat_val = 12'h000;
		endcase
	endfunction

	function automatic logic [11:0] fmt_val(rft_pixfmt_t f, logic [11:0] d);
		case (f)
			RFT_PF_8: fmt_val = {4'h0, d[11:4]};
			RFT_PF_10: fmt_val = {2'h0, d[11:2]};
			default: fmt_val = d;
		endcase
	endfunction

	rft_scan_st_t st_reg;
	logic [9:0] hb_reg;
	logic [10:0] col_reg;
	logic [10:0] row_reg;
	rft_pix_t pix_reg;

	wire [11:0] col_last = 12'({1'b0, roi.offset_x} + {1'b0, roi.width} - 12'h001);
	wire [11:0] row_last = 12'({1'b0, roi.offset_y} + {1'b0, roi.height} - 12'h001);
	wire line_end = {1'b0, col_reg} == col_last;
	wire frame_end = {1'b0, row_reg} == row_last;
	wire in_line = st_reg == RFT_SC_LINE;
	wire [11:0] raw = (pattern == RFT_TP_OFF) ? sensor_pixel : pat_val(pattern, col_reg, row_reg, frame_idx);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= RFT_SC_IDLE;
			hb_reg <= 10'h000;
			col_reg <= 11'h000;
			row_reg <= 11'h000;
		end else begin
			case (st_reg)
				RFT_SC_IDLE: if (start) begin
					st_reg <= RFT_SC_LINE;
					col_reg <= roi.offset_x;
					row_reg <= roi.offset_y;
				end
				RFT_SC_LINE: if (line_end) begin
					st_reg <= RFT_SC_HBLK;
					hb_reg <= HB >> tap;
				end else begin
					col_reg <= col_reg + 11'h001;
				end
				RFT_SC_HBLK: if (hb_reg != 10'h000) begin
					hb_reg <= hb_reg - 10'h001;
				end else if (frame_end) begin
					st_reg <= RFT_SC_IDLE;
				end else begin
					st_reg <= RFT_SC_LINE;
					row_reg <= row_reg + 11'h001;
					col_reg <= roi.offset_x;
				end
				default: st_reg <= RFT_SC_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pix_reg <= '0;
		end else begin
			pix_reg.valid <= in_line;
			pix_reg.sof <= in_line && col_reg == roi.offset_x && row_reg == roi.offset_y;
			pix_reg.eol <= in_line && line_end;
			pix_reg.data <= fmt_val(pixfmt, raw);
		end
	end

	assign busy = st_reg != RFT_SC_IDLE;
	assign sensor_col = col_reg;
	assign sensor_row = row_reg;
	assign pix = pix_reg;
endmodule

// ==== logic/rft_top.sv ====
// Image format and frame trigger block with AXI4-Lite registers
// Functional notes
// - Horizontal offset 0..1840, default 0
// - Vertical offset 0..1214, default 0
// - 8/10/12-bit formats; 12-bit needs bypass
// - Read-only colour filter: none or Bayer
// - Selectable test image replaces sensor data
// - Frame rate 0.125..127.975 Hz, ROI-limited
// - Trigger target fixed read-only frame start
// - Trigger mode off free-runs, on triggers
// - Software trigger command issues one event
// - Trigger source mux, default CC1 line
// - Rising, falling, high or low qualification
// - Width 96..1936, width plus offset bounded
// - Format settings change only while stopped
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rft_consts.svh"
module rft_top #(
	parameter bit COLOR_VARIANT = 1'b0,
	parameter int ADDR_W = 8,
	parameter int HBLANK = 64
) (
	input wire logic aclk, // Clock, 20 MHz
	input wire logic aresetn, // Sync reset, low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic pulse_source_zero, // Internal pulse
	input wire logic user_drive_zero, // User output 0
	input wire logic user_drive_one, // User output 1
	input wire logic ttl_input_line, // TTL input
	input wire logic cc1_line, // Control line CC1
	input wire logic nand_gate_a_output, // NAND gate A
	input wire logic nand_gate_b_output, // NAND gate B
	input wire logic [11:0] sensor_pixel, // Sensor data
	output logic frame_start, // One-cycle frame pulse
	output rft_pkg::rft_roi_t roi_out, // Active region
	output logic [10:0] sensor_col, // Sensor column
	output logic [10:0] sensor_row, // Sensor row
	output rft_pkg::rft_pix_t pix_out // Output pixel stream
);
	import rft_pkg::*;

	if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk
		$error("rft_top: ADDR_W out of range");
	end

	// ****************************************
	// Register state
	// ****************************************
	logic run_reg;
	logic byp_reg;
	rft_roi_t roi_reg;
	rft_pixfmt_t fmt_reg;
	rft_pat_t pat_reg;
	logic [16:0] rate_reg;
	logic tap_reg;
	logic trig_mode_reg;
	rft_src_t src_reg;
	rft_act_t act_reg;
	logic sw_fire_reg;

	// ****************************************
	// Bus state
	// ****************************************
	logic awready_reg;
	logic aw_full_reg;
	logic aw_bad_reg;
	logic [3:0] aw_idx_reg;
	logic wready_reg;
	logic w_full_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// ****************************************
	// Frame timing state
	// ****************************************
	logic [35:0] acc_reg;
	logic pend_reg;
	logic trig_prev_reg;
	logic frame_start_reg;
	logic [15:0] fcnt_reg;
	logic busy;

	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ****************************************
	// Read bank
	// ****************************************
	wire [31:0] rd_bank [16];
	wire waiting = run_reg & trig_mode_reg & ~busy;

	assign rd_bank[`RFT_I_CTRL] = {30'h0, byp_reg, run_reg};
	assign rd_bank[`RFT_I_OFFX] = {21'h0, roi_reg.offset_x};
	assign rd_bank[`RFT_I_OFFY] = {21'h0, roi_reg.offset_y};
	assign rd_bank[`RFT_I_WIDTH] = {21'h0, roi_reg.width};
	assign rd_bank[`RFT_I_HEIGHT] = {21'h0, roi_reg.height};
	assign rd_bank[`RFT_I_PIXFMT] = {30'h0, fmt_reg};
	assign rd_bank[`RFT_I_CFILT] = {31'h0, COLOR_VARIANT};
	assign rd_bank[`RFT_I_TPAT] = {29'h0, pat_reg};
	assign rd_bank[`RFT_I_RATE] = {15'h0, rate_reg};
	assign rd_bank[`RFT_I_TAP] = {31'h0, tap_reg};
	assign rd_bank[`RFT_I_TSEL] = `RFT_TSEL_FRAME_START;
	assign rd_bank[`RFT_I_TMODE] = {31'h0, trig_mode_reg};
	assign rd_bank[`RFT_I_TSW] = 32'h00000000;
	assign rd_bank[`RFT_I_TSRC] = {28'h0, src_reg};
	assign rd_bank[`RFT_I_TACT] = {30'h0, act_reg};
	assign rd_bank[`RFT_I_STAT] = {fcnt_reg, 13'h0, waiting, pend_reg, busy};

	// ****************************************
	// Write decode and value checks
	// ****************************************
	wire aw_hs = s_axi_awvalid & awready_reg;
	wire w_hs = s_axi_wvalid & wready_reg;
	wire ar_hs = s_axi_arvalid & arready_reg;
	wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire [31:0] wv = merge(rd_bank[aw_idx_reg], wdata_reg, wstrb_reg);
	wire [10:0] v11 = wv[10:0];
	wire narrow = ~|wv[31:11];
	wire stopped = ~run_reg;
	wire [11:0] x_span = 12'(v11) + 12'((aw_idx_reg == `RFT_I_WIDTH) ? roi_reg.offset_x : roi_reg.width);
	wire [11:0] y_span = 12'(v11) + 12'((aw_idx_reg == `RFT_I_HEIGHT) ? roi_reg.offset_y : roi_reg.height);
	wire pf_ok = wv[1:0] == RFT_PF_8 || wv[1:0] == RFT_PF_10 || (wv[1:0] == RFT_PF_12 && byp_reg);
	wire tp_ok = wv[2:0] <= RFT_TP_GREY_H_MOVE || (COLOR_VARIANT && wv[2:0] <= RFT_TP_BAR_MOVE);
	wire [15:0] ok_vec;

	assign ok_vec[`RFT_I_CTRL] = ~|wv[31:2] & (wv[`RFT_CTRL_BYP] | fmt_reg != RFT_PF_12);
	assign ok_vec[`RFT_I_OFFX] = stopped & narrow & v11 <= `RFT_OFFX_MAX & x_span <= `RFT_SENSOR_W;
	assign ok_vec[`RFT_I_OFFY] = stopped & narrow & v11 <= `RFT_OFFY_MAX & y_span <= `RFT_SENSOR_H;
	assign ok_vec[`RFT_I_WIDTH] = stopped & narrow & v11 >= `RFT_WIDTH_MIN & x_span <= `RFT_SENSOR_W;
	assign ok_vec[`RFT_I_HEIGHT] = stopped & narrow & v11 >= `RFT_HEIGHT_MIN & y_span <= `RFT_SENSOR_H;
	assign ok_vec[`RFT_I_PIXFMT] = stopped & ~|wv[31:2] & pf_ok;
	assign ok_vec[`RFT_I_CFILT] = 1'b0;
	assign ok_vec[`RFT_I_TPAT] = stopped & ~|wv[31:3] & tp_ok;
	assign ok_vec[`RFT_I_RATE] = ~|wv[31:17] & wv[16:0] >= `RFT_RATE_MIN & wv[16:0] <= `RFT_RATE_MAX;
	assign ok_vec[`RFT_I_TAP] = stopped & ~|wv[31:1];
	assign ok_vec[`RFT_I_TSEL] = 1'b0;
	assign ok_vec[`RFT_I_TMODE] = ~|wv[31:1];
	assign ok_vec[`RFT_I_TSW] = 1'b1;
	assign ok_vec[`RFT_I_TSRC] = ~|wv[31:4] & wv[3:0] <= `RFT_SRC_LAST;
	assign ok_vec[`RFT_I_TACT] = ~|wv[31:2];
	assign ok_vec[`RFT_I_STAT] = 1'b0;

	wire wr_ok = ~aw_bad_reg & ok_vec[aw_idx_reg];
	wire [15:0] we = {16{do_wr & wr_ok}} & (16'h0001 << aw_idx_reg);

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_reg <= 1'b0;
			byp_reg <= 1'b0;
			roi_reg <= {11'h000, 11'h000, `RFT_WIDTH_RST, `RFT_HEIGHT_RST};
			fmt_reg <= RFT_PF_8;
			pat_reg <= RFT_TP_OFF;
			rate_reg <= `RFT_RATE_RST;
			tap_reg <= 1'b0;
			trig_mode_reg <= 1'b0;
			src_reg <= rft_src_t'(`RFT_RST_SRC);
			act_reg <= rft_act_t'(`RFT_RST_ACT);
		end else begin
			if (we[`RFT_I_CTRL]) {byp_reg, run_reg} <= wv[1:0];
			if (we[`RFT_I_OFFX]) roi_reg.offset_x <= v11;
			if (we[`RFT_I_OFFY]) roi_reg.offset_y <= v11;
			if (we[`RFT_I_WIDTH]) roi_reg.width <= v11;
			if (we[`RFT_I_HEIGHT]) roi_reg.height <= v11;
			if (we[`RFT_I_PIXFMT]) fmt_reg <= rft_pixfmt_t'(wv[1:0]);
			if (we[`RFT_I_TPAT]) pat_reg <= rft_pat_t'(wv[2:0]);
			if (we[`RFT_I_RATE]) rate_reg <= wv[16:0];
			if (we[`RFT_I_TAP]) tap_reg <= wv[0];
			if (we[`RFT_I_TMODE]) trig_mode_reg <= wv[0];
			if (we[`RFT_I_TSRC]) src_reg <= rft_src_t'(wv[3:0]);
			if (we[`RFT_I_TACT]) act_reg <= rft_act_t'(wv[1:0]);
		end
	end

	// One-cycle software trigger event
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_fire_reg <= 1'b0;
		end else begin
			sw_fire_reg <= we[`RFT_I_TSW] & wv[`RFT_TSW_FIRE];
		end
	end

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	wire aw_full_next = aw_hs | (aw_full_reg & ~do_wr);
	wire w_full_next = w_hs | (w_full_reg & ~do_wr);
	wire bvalid_next = do_wr | (bvalid_reg & ~s_axi_bready);
	wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
	wire ar_bad = |s_axi_araddr[ADDR_W-1:6];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			aw_full_reg <= 1'b0;
			aw_bad_reg <= 1'b0;
			aw_idx_reg <= 4'h0;
			wready_reg <= 1'b0;
			w_full_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RFT_RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			bvalid_reg <= bvalid_next;
			awready_reg <= ~aw_full_next & ~bvalid_next;
			wready_reg <= ~w_full_next & ~bvalid_next;
			if (aw_hs) begin
				aw_idx_reg <= s_axi_awaddr[5:2];
				aw_bad_reg <= |s_axi_awaddr[ADDR_W-1:6];
			end
			if (w_hs) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				bresp_reg <= aw_bad_reg ? `RFT_RESP_DECERR : (wr_ok ? `RFT_RESP_OKAY : `RFT_RESP_SLVERR);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RFT_RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			arready_reg <= ~rvalid_next;
			if (ar_hs) begin
				rdata_reg <= ar_bad ? 32'h00000000 : rd_bank[s_axi_araddr[5:2]];
				rresp_reg <= ar_bad ? `RFT_RESP_DECERR : `RFT_RESP_OKAY;
			end
		end
	end

	// ****************************************
	// Trigger selection and qualification
	// ****************************************
	wire [9:0] src_vec = {nand_gate_b_output, nand_gate_a_output, cc1_line, ttl_input_line,
		user_drive_one, user_drive_zero, pulse_source_zero, sw_fire_reg, 1'b1, 1'b0};
	wire trig_raw = src_vec[src_reg];
	wire trig_rise = trig_raw & ~trig_prev_reg;
	wire trig_fall = ~trig_raw & trig_prev_reg;
	wire trig_qual = (act_reg == RFT_ACT_RISE) ? trig_rise :
		(act_reg == RFT_ACT_FALL) ? trig_fall :
		(act_reg == RFT_ACT_HIGH) ? trig_raw : ~trig_raw;

	// ****************************************
	// Frame rate accumulator and start
	// ****************************************
	wire [35:0] acc_sum = acc_reg + 36'(rate_reg);
	wire tick = acc_sum >= `RFT_ACC_WRAP;
	wire start_c = run_reg & ~busy & (trig_mode_reg ? trig_qual : pend_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_reg <= 36'h000000000;
			pend_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			frame_start_reg <= 1'b0;
			fcnt_reg <= 16'h0000;
		end else begin
			trig_prev_reg <= trig_raw;
			frame_start_reg <= start_c;
			fcnt_reg <= fcnt_reg + {15'h0000, start_c};
			if (!run_reg) begin
				acc_reg <= 36'h000000000;
				pend_reg <= 1'b0;
			end else begin
				acc_reg <= tick ? acc_sum - `RFT_ACC_WRAP : acc_sum;
				// A new tick wins over the start consuming an older one
				if (tick & ~trig_mode_reg) pend_reg <= 1'b1;
				else if (start_c | trig_mode_reg) pend_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Readout scanner
	// ****************************************
	rft_scan #(
		.HBLANK(HBLANK)
	) u_scan (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start_c),
		.roi(roi_reg),
		.tap(tap_reg),
		.pattern(pat_reg),
		.pixfmt(fmt_reg),
		.frame_idx(fcnt_reg[7:0]),
		.sensor_pixel(sensor_pixel),
		.busy(busy),
		.sensor_col(sensor_col),
		.sensor_row(sensor_row),
		.pix(pix_out)
	);

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign frame_start = frame_start_reg;
	assign roi_out = roi_reg;
endmodule

// ==== tb/rft_properties.sv ====
// Port assertions for the format and trigger block
`timescale 1ns/1ps
module rft_properties (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B resp
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic frame_start, // Frame pulse
	input wire rft_pkg::rft_roi_t roi_out, // Region
	input wire logic [10:0] sensor_col, // Column
	input wire logic [10:0] sensor_row, // Row
	input wire rft_pkg::rft_pix_t pix_out // Pixels
);
	import rft_pkg::*;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ****************
	// Port relations
	// ****************
	wr_resp_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response not on time");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not on time");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	fs_pulse_a: assert property (frame_start |=> !frame_start)
		else $error("frame pulse too long");
	start_addr_a: assert property (frame_start |-> sensor_col == roi_out.offset_x && sensor_row == roi_out.offset_y)
		else $error("readout start not at offsets");
	first_pix_a: assert property (frame_start |=> pix_out.valid && pix_out.sof)
		else $error("first pixel not after frame pulse");
	eol_gap_a: assert property (pix_out.eol |=> !pix_out.valid)
		else $error("no blanking after line end");
	roi_bound_a: assert property (roi_out.offset_x <= 11'h730 && roi_out.offset_y <= 11'h4BE
		&& {1'b0, roi_out.offset_x} + {1'b0, roi_out.width} <= 12'h790)
		else $error("region outside sensor");
	frame_c: cover property (frame_start);
	eol_c: cover property (pix_out.eol);
	slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind rft_top rft_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frame_start, .roi_out, .sensor_col, .sensor_row, .pix_out);

// ==== tb/rft_sensor_model.sv ====
// Sensor array model answering the readout address
`timescale 1ns/1ps
module rft_sensor_model (
	input wire logic [10:0] sensor_col, // Column address
	input wire logic [10:0] sensor_row, // Row address
	output logic [11:0] sensor_pixel // Pixel at address
);
	assign sensor_pixel = {sensor_row[3:0], sensor_col[7:0]};
endmodule

// ==== tb/tb_roi_format_and_frame_trigger.sv ====
// Self-checking bench for the format and trigger block
`timescale 1ns/1ps
`include "rft_consts.svh"
module tb_roi_format_and_frame_trigger;
	import rft_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_start;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [9:3] lines;
	logic [11:0] sensor_pixel, first_data;
	logic [10:0] sensor_col, sensor_row, ox, oy;
	rft_roi_t roi_out;
	rft_pix_t pix_out;
	rft_act_t act;
	int bad_count, n_checks, fs_cnt, pix_cnt, pc;

	rft_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_source_zero(lines[3]),
		.user_drive_zero(lines[4]), .user_drive_one(lines[5]), .ttl_input_line(lines[6]), .cc1_line(lines[7]),
		.nand_gate_a_output(lines[8]), .nand_gate_b_output(lines[9]), .sensor_pixel, .frame_start, .roi_out,
		.sensor_col, .sensor_row, .pix_out);
	rft_sensor_model sens (.sensor_col, .sensor_row, .sensor_pixel);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (frame_start === 1'b1) fs_cnt <= fs_cnt + 1;
		if (pix_out.valid === 1'b1) pix_cnt <= pix_cnt + 1;
		if (pix_out.sof === 1'b1) first_data <= pix_out.data;
	end

	function automatic logic [11:0] exp_pix(input logic [10:0] c, input logic [10:0] r);
		return {4'h0, r[3:0], c[7:4]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wc(input logic [4:0] i, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		s_axi_awaddr <= {1'b0, i, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($urandom_range(1, 0));
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
		s_axi_bready <= 1'b0;
		chk("bresp", e, s_axi_bresp);
	endtask

	task automatic rc(input logic [4:0] i, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= {1'b0, i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom_range(1, 0));
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", i[4] ? 32'h3 : 32'h0, s_axi_rresp);
	endtask

	task automatic fw(input int lim, input logic e);
		int s;
		s = fs_cnt;
		for (int k = 0; k < lim && fs_cnt == s; k++) @(posedge aclk);
		chk("frame", e, fs_cnt != s);
	endtask

	task automatic arm(input logic [3:0] s, input logic [1:0] a, input logic m);
		wc(`RFT_I_CTRL, 32'h0, 2'h0);
		wc(`RFT_I_OFFX, ox, 2'h0);
		wc(`RFT_I_OFFY, oy, 2'h0);
		wc(`RFT_I_TSRC, s, 2'h0);
		wc(`RFT_I_TACT, a, 2'h0);
		wc(`RFT_I_TMODE, m, 2'h0);
		wc(`RFT_I_CTRL, 32'h1, 2'h0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end

	// ****************
	// Stimulus
	// ****************
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		lines = 7'h00;
		{fs_cnt, pix_cnt, bad_count, n_checks} = 128'h0;
		void'($urandom(24));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`RFT_I_OFFX, 32'h0);
		rc(`RFT_I_OFFY, 32'h0);
		rc(`RFT_I_WIDTH, 32'h790);
		rc(`RFT_I_PIXFMT, 32'h0);
		rc(`RFT_I_CFILT, 32'h0);
		rc(`RFT_I_TPAT, 32'h0);
		rc(`RFT_I_RATE, 32'h1D563);
		rc(`RFT_I_TSEL, 32'h0);
		rc(`RFT_I_TMODE, 32'h0);
		rc(`RFT_I_TSRC, 32'h7);
		rc(`RFT_I_TACT, 32'h0);
		rc(`RFT_I_TSW, 32'h0);
		rc(`RFT_I_STAT, 32'h0);
		wc(`RFT_I_WIDTH, 32'h5F, 2'h2);
		wc(`RFT_I_WIDTH, 32'h60, 2'h0);
		wc(`RFT_I_HEIGHT, 32'h2, 2'h0);
		wc(`RFT_I_OFFX, 32'h731, 2'h2);
		wc(`RFT_I_OFFX, 32'h730, 2'h0);
		wc(`RFT_I_OFFY, 32'h4BF, 2'h2);
		wc(`RFT_I_OFFY, 32'h4BE, 2'h0);
		rc(`RFT_I_OFFX, 32'h730);
		wc(`RFT_I_PIXFMT, 32'h2, 2'h2);
		wc(`RFT_I_CTRL, 32'h2, 2'h0);
		wc(`RFT_I_PIXFMT, 32'h2, 2'h0);
		wc(`RFT_I_CTRL, 32'h0, 2'h2);
		wc(`RFT_I_PIXFMT, 32'h0, 2'h0);
		wc(`RFT_I_TPAT, 32'h4, 2'h2);
		wc(`RFT_I_TPAT, 32'h3, 2'h0);
		wc(`RFT_I_TPAT, 32'h0, 2'h0);
		wc(`RFT_I_RATE, 32'h7C, 2'h2);
		wc(`RFT_I_RATE, 32'h1F3E8, 2'h2);
		wc(`RFT_I_RATE, 32'h7D, 2'h0);
		wc(`RFT_I_RATE, 32'h1F3E7, 2'h0);
		wc(`RFT_I_TSEL, 32'h1, 2'h2);
		wc(`RFT_I_CFILT, 32'h1, 2'h2);
		wc(`RFT_I_TSRC, 32'hA, 2'h2);
		wc(5'h10, 32'h0, 2'h3);
		rc(5'h10, 32'h0);
		wc(`RFT_I_CTRL, 32'h1, 2'h0);
		wc(`RFT_I_OFFX, 32'h0, 2'h2);
		ox = 11'h730;
		oy = 11'h4BE;
		for (int s = 3; s <= 9; s++) begin
			act = (s % 2) ? RFT_ACT_FALL : RFT_ACT_RISE;
			lines[s] <= (act == RFT_ACT_FALL);
			arm(4'(s), act, 1'b1);
			pc = pix_cnt;
			lines[s] <= (act != RFT_ACT_FALL);
			fw(20, 1'b1);
			repeat (400) @(posedge aclk);
			chk("pixels", 32'hC0, pix_cnt - pc);
			chk("first pixel", exp_pix(ox, oy), first_data);
			lines[s] <= 1'b0;
			ox = 11'($urandom_range(1840, 0));
			oy = 11'($urandom_range(1214, 0));
		end
		arm(RFT_SRC_SOFT, RFT_ACT_RISE, 1'b1);
		wc(`RFT_I_TSW, 32'h1, 2'h0);
		fw(20, 1'b1);
		arm(RFT_SRC_CC1, RFT_ACT_RISE, 1'b0);
		lines[7] <= 1'b1;
		fw(1000, 1'b0);
		lines[7] <= 1'b0;
		arm(RFT_SRC_LOW, RFT_ACT_RISE, 1'b1);
		fw(300, 1'b0);
		arm(RFT_SRC_HIGH, RFT_ACT_LOW, 1'b1);
		fw(300, 1'b0);
		arm(RFT_SRC_HIGH, RFT_ACT_HIGH, 1'b1);
		fw(20, 1'b1);
		fw(400, 1'b1);
		arm(RFT_SRC_LOW, RFT_ACT_LOW, 1'b1);
		fw(600, 1'b1);
		report_and_stop();
	end
endmodule
